// *** src/enf_defs.svh ***
/*
  Offsets, field positions, reset values and counts for the E1 national-bit event flags.
  Assumes it is included by bare name from the package and the design module.
*/
`ifndef ENF_DEFS_SVH
`define ENF_DEFS_SVH

// Register byte offsets on the AXI4-Lite slave
`define ENF_SA6_IRQ_EN_OFS 12'h000
`define ENF_ZSTAT_OFS 12'h004
`define ENF_ZIRQ_EN_OFS 12'h008
`define ENF_SA6_FLAG_OFS 12'h00C

// Sa6 enable field positions
`define ENF_B_ALL_ZERO 0
`define ENF_B_MISC 1
`define ENF_B_P001X 2
`define ENF_B_P1000 3
`define ENF_B_P1010 4
`define ENF_B_P1100 5

// Sa7 and zero-run field positions
`define ENF_B_ZRUN 0
`define ENF_B_SA7 1
`define ENF_B_SA7_STATE 5

// Reset values
`define ENF_EN_RST 8'h00
`define ENF_FLAG_RST 8'h00

// Sa7 majority vote window
`define ENF_VOTE_LEN 3
`define ENF_VOTE_MIN 2

// AXI responses
`define ENF_RESP_OKAY 2'b00
`define ENF_RESP_SLVERR 2'b10

`endif

// *** src/enf_pkg.sv ***
/*
  Types for the E1 national-bit event flags.
  Assumes enf_defs.svh sits in the include path.
*/
`include "enf_defs.svh"

package enf_pkg;
  // Event inputs sampled each framer clock
  typedef struct packed {
    logic sa6_valid;     // New debounced Sa6 nibble present
    logic [3:0] sa6;     // Debounced Sa6 nibble
    logic sa7_valid;     // New received Sa7 bit present
    logic sa7;           // Received Sa7 bit
    logic zero_run;      // Excessive-zero condition level
  } enf_evt_t;

  // Write channel handshake states
  typedef enum logic [2:0] {
    ENF_W_IDLE = 3'b001,
    ENF_W_HAVE = 3'b010,
    ENF_W_RESP = 3'b100
  } enf_wstate_t;
endpackage

// *** src/enf_flags.sv ***
/*
  E1 national-bit event flags: Sa6 pattern change events, Sa7 majority state,
  excessive-zero change flag, enables and one interrupt output, on AXI4-Lite.
  Assumes event inputs are synchronous to aclk and held valid one cycle each.
*/
// Contract
// - Sa6 unmatched pattern raises gated interrupt
// - Sa6 0000 entry and exit raise event
// - Sa6 enables reset zero, read back
// - Sa7 zero state: two of three
// - Read-only Sa7 state at bit 5
// - Sa7 change flag on set and clear
// - Change flags latch, clear on status read
// - Zero-run flag on detect and clear
// - Sa6 1100/1010/1000/001x change enables
// - Sa7 and zero-run enables reset zero
`timescale 1ns/1ps
`include "enf_defs.svh"

module enf_flags
  import enf_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Framer events
  input wire enf_evt_t evt,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);

  logic [7:0] sa6_en;      // Sa6 enables
  logic [7:0] z_en;        // Sa7 and zero-run enables
  logic [7:0] sa6_flag;    // Sa6 sticky flags
  logic [1:0] z_flag;      // Sa7 and zero-run sticky flags
  logic [5:0] sa6_match;   // Current pattern matches, held
  logic sa7_zero_state;    // Declared Sa7-equals-zero
  logic [2:0] sa7_hist;    // Last three Sa7 observations
  logic [1:0] sa7_cnt;     // Observations seen, up to three
  logic zero_run_q;        // Previous zero-run level
  enf_wstate_t wstate;
  logic [11:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic have_aw;
  logic have_w;
  logic [5:0] next_match;
  logic next_sa7_state;
  logic [2:0] next_hist;
  logic [1:0] zeros;
  logic wr_fire;
  logic rd_fire;
  logic rd_zstat;
  logic rd_sa6f;
  logic [5:0] sa6_evt;
  logic sa7_evt;
  logic zrun_evt;

  // Pattern decode of the incoming nibble
  always_comb begin
    next_match = 6'h00;
    next_match[`ENF_B_ALL_ZERO] = (evt.sa6 == 4'h0);
    next_match[`ENF_B_P001X] = (evt.sa6[3:1] == 3'b001);
    next_match[`ENF_B_P1000] = (evt.sa6 == 4'h8);
    next_match[`ENF_B_P1010] = (evt.sa6 == 4'hA);
    next_match[`ENF_B_P1100] = (evt.sa6 == 4'hC);
    // Misc is a level: asserted while no listed pattern matches
    next_match[`ENF_B_MISC] = ~(next_match[0] | next_match[2] | next_match[3]
      | next_match[4] | next_match[5]);
  end

  // Sa6 events: change for listed patterns, entry into misc only
  always_comb begin
    sa6_evt = 6'h00;
    if (evt.sa6_valid) begin
      sa6_evt = next_match ^ sa6_match;
      sa6_evt[`ENF_B_MISC] = next_match[`ENF_B_MISC] & ~sa6_match[`ENF_B_MISC];
    end
  end

  // Sa7 two-of-three vote over the newest observation window
  always_comb begin
    next_hist = {sa7_hist[1:0], evt.sa7};
    zeros = 2'(!next_hist[0]) + 2'(!next_hist[1]) + 2'(!next_hist[2]);
    next_sa7_state = sa7_zero_state;
    // Vote only once three bits are real, avoiding a reset-bias artefact
    if (evt.sa7_valid && (sa7_cnt >= 2'd2)) begin
      next_sa7_state = (zeros >= 2'(`ENF_VOTE_MIN));
    end
  end

  assign sa7_evt = next_sa7_state ^ sa7_zero_state;
  assign zrun_evt = evt.zero_run ^ zero_run_q;

  // Sa6 pattern state tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sa6_match <= 6'h00;
    end else if (evt.sa6_valid) begin
      sa6_match <= next_match;
    end
  end

  // Sa7 history and declared state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sa7_hist <= 3'h7;
      sa7_cnt <= 2'd0;
      sa7_zero_state <= 1'b0;
    end else begin
      sa7_zero_state <= next_sa7_state;
      if (evt.sa7_valid) begin
        sa7_hist <= next_hist;
        if (sa7_cnt != 2'd3) begin
          sa7_cnt <= sa7_cnt + 2'd1;
        end
      end
    end
  end

  // Zero-run edge memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_run_q <= 1'b0;
    end else begin
      zero_run_q <= evt.zero_run;
    end
  end

  // Write channel: address and data in either order
  assign wr_fire = have_aw && have_w && (wstate != ENF_W_RESP);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= ENF_W_IDLE;
      have_aw <= 1'b0;
      have_w <= 1'b0;
      waddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ENF_RESP_OKAY;
    end else begin
      case (wstate)
        ENF_W_IDLE, ENF_W_HAVE: begin
          s_axi_awready <= !have_aw && !s_axi_awready;
          s_axi_wready <= !have_w && !s_axi_wready;
          if (s_axi_awvalid && s_axi_awready) begin
            have_aw <= 1'b1;
            waddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            have_w <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
          end
          if (have_aw || have_w) begin
            wstate <= ENF_W_HAVE;
          end
          if (wr_fire) begin
            wstate <= ENF_W_RESP;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (waddr_q == `ENF_SA6_IRQ_EN_OFS || waddr_q == `ENF_ZSTAT_OFS
                || waddr_q == `ENF_ZIRQ_EN_OFS || waddr_q == `ENF_SA6_FLAG_OFS) begin
              s_axi_bresp <= `ENF_RESP_OKAY;
            end else begin
              s_axi_bresp <= `ENF_RESP_SLVERR;
            end
          end
        end
        ENF_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            have_aw <= 1'b0;
            have_w <= 1'b0;
            wstate <= ENF_W_IDLE;
          end
        end
        default: begin
          wstate <= ENF_W_IDLE;
        end
      endcase
    end
  end

  // Enable registers; only lane 0 carries bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sa6_en <= `ENF_EN_RST;
      z_en <= `ENF_EN_RST;
    end else if (wr_fire && wstrb_q[0]) begin
      if (waddr_q == `ENF_SA6_IRQ_EN_OFS) begin
        sa6_en <= {2'b00, wdata_q[5:0]};
      end else if (waddr_q == `ENF_ZIRQ_EN_OFS) begin
        z_en <= {6'h00, wdata_q[1:0]};
      end
    end
  end

  // Read channel, one cycle to rvalid
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_zstat = rd_fire && (s_axi_araddr == `ENF_ZSTAT_OFS);
  assign rd_sa6f = rd_fire && (s_axi_araddr == `ENF_SA6_FLAG_OFS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ENF_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ENF_RESP_OKAY;
      if (s_axi_araddr == `ENF_SA6_IRQ_EN_OFS) begin
        s_axi_rdata <= {24'h00_0000, sa6_en};
      end else if (s_axi_araddr == `ENF_ZSTAT_OFS) begin
        s_axi_rdata <= {26'h000_0000, sa7_zero_state, 3'b000, z_flag};
      end else if (s_axi_araddr == `ENF_ZIRQ_EN_OFS) begin
        s_axi_rdata <= {24'h00_0000, z_en};
      end else if (s_axi_araddr == `ENF_SA6_FLAG_OFS) begin
        s_axi_rdata <= {24'h00_0000, sa6_flag};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `ENF_RESP_SLVERR;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Sticky flags; an event in the read cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      z_flag <= 2'b00;
      sa6_flag <= `ENF_FLAG_RST;
    end else begin
      z_flag <= (rd_zstat ? 2'b00 : z_flag) | {sa7_evt, zrun_evt};
      sa6_flag <= (rd_sa6f ? 8'h00 : sa6_flag) | {2'b00, sa6_evt};
    end
  end

  // Interrupt output, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sa6_flag & sa6_en) | |(z_flag & z_en[1:0]);
    end
  end

  // Checks
  sa7_vote_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (evt.sa7_valid && sa7_cnt == 2'd3 && zeros >= 2'd2) |=> sa7_zero_state)
    else $error("Sa7 vote did not declare zero state");
  sa7_state_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_fire && s_axi_araddr == 12'h004 && !s_axi_rvalid)
      |=> (s_axi_rdata[5] == $past(sa7_zero_state)))
    else $error("Sa7 state bit misreported");
  sa7_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(sa7_zero_state) |-> z_flag[1])
    else $error("Sa7 change flag not set");
  zrun_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (evt.zero_run != zero_run_q) |=> z_flag[0])
    else $error("Zero-run change flag not set");
  flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_zstat && !sa7_evt && !zrun_evt) |=> (z_flag == 2'b00))
    else $error("Status read did not clear flags");
  sa6_zero_evt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (evt.sa6_valid && ((evt.sa6 == 4'h0) != sa6_match[0])) |=> sa6_flag[0])
    else $error("Sa6 all-zero change missed");
  sa6_misc_evt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sa6_evt[1] && sa6_en[1]) |=> ##1 irq)
    else $error("Misc pattern interrupt missing");
  en_reset_a: assert property (@(posedge aclk)
    !aresetn |=> (sa6_en == 8'h00 && z_en == 8'h00))
    else $error("Enables not reset to zero");
  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((sa6_flag & sa6_en) == 8'h00 && (z_flag & z_en[1:0]) == 2'b00) |=> !irq)
    else $error("Interrupt without enabled flag");
endmodule

// *** testbench/test_e1_national_bit_event_flags.sv ***
/*
  Self-checking bench for the E1 national-bit event flags: register access over AXI4-Lite,
  Sa6 pattern change flags, Sa7 two-of-three state, zero-run change flag and the interrupt.
  Assumes the enf_flags design, enf_pkg and enf_defs.svh are compiled first.
*/
`timescale 1ns/1ps
`include "enf_defs.svh"

module test_e1_national_bit_event_flags;
  import enf_pkg::*;
  // Clock, reset and ports
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  enf_evt_t evt = '0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // Bench state
  int n_fail = 0, checks_done = 0, cycles = 0, i;
  logic [31:0] d, en6, en2;
  logic [1:0] r;
  logic [3:0] nib;
  logic b, z = 0, st = 0, prev_st;
  logic [5:0] prev6 = '0, f6 = '0; // Sa6 match classes and sticky flags
  logic [1:0] f2 = '0;             // Sa7 flag, zero-run flag
  logic [2:0] hist = '0;           // Last three Sa7 bits
  int seen = 0;

  enf_flags dut (.aclk(aclk), .aresetn(aresetn), .evt(evt),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq));

  // Free-running 250 MHz clock
  always #2 aclk = ~aclk;

  // Watchdog: far above the roughly 1300 cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
      output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) begin
        v = rdata;
        resp = rresp;
        rready <= 0;
        break;
      end
    end
  endtask

  // Which listed Sa6 patterns a nibble matches; bit 1 means none of them
  function automatic logic [5:0] sa6_class(input logic [3:0] n);
    logic [5:0] c;
    c = '0;
    c[`ENF_B_ALL_ZERO] = (n == 4'h0);
    c[`ENF_B_P001X] = (n[3:1] == 3'b001);
    c[`ENF_B_P1000] = (n == 4'h8);
    c[`ENF_B_P1010] = (n == 4'ha);
    c[`ENF_B_P1100] = (n == 4'hc);
    c[`ENF_B_MISC] = (c == 6'h00);
    return c;
  endfunction

  initial begin
    void'($urandom(32'h5bb541ec));
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    // Reset values, unmapped place, ignored writes
    for (i = 0; i < 4; i++) begin
      axi_rd(12'(i * 4), d, r);
      check(d, 32'h0000_0000);
    end
    check(irq, 1'b0);
    axi_rd(12'h010, d, r);
    check(r, `ENF_RESP_SLVERR);
    axi_wr(12'h010, 32'hffff_ffff, 4'hf, r);
    check(r, `ENF_RESP_SLVERR);
    axi_wr(`ENF_ZSTAT_OFS, 32'hffff_ffff, 4'hf, r);
    axi_rd(`ENF_ZSTAT_OFS, d, r);
    check(d, 32'h0000_0000);
    axi_wr(`ENF_SA6_IRQ_EN_OFS, 32'h0000_003f, 4'h0, r);
    axi_rd(`ENF_SA6_IRQ_EN_OFS, d, r);
    check(d, 32'h0000_0000);
    // Random event stream with a reference model; first nibble fixed at 0000
    for (i = 0; i < 80; i++) begin
      if (i % 10 == 0) begin
        en6 = $urandom;
        en2 = $urandom;
        axi_wr(`ENF_SA6_IRQ_EN_OFS, en6, 4'hf, r);
        check(r, `ENF_RESP_OKAY);
        axi_wr(`ENF_ZIRQ_EN_OFS, en2, 4'hf, r);
        axi_rd(`ENF_SA6_IRQ_EN_OFS, d, r);
        check(d, en6 & 32'h0000_003f);
        axi_rd(`ENF_ZIRQ_EN_OFS, d, r);
        check(d, en2 & 32'h0000_0003);
      end
      nib = (i == 0) ? 4'h0 : 4'($urandom_range(15));
      b = 1'($urandom_range(1));
      // Any level change on the zero-run input latches its change flag
      if (i > 0 && $urandom_range(3) == 0) begin
        z = ~z;
        f2[0] = 1;
      end
      @(posedge aclk);
      evt <= '{sa6_valid: 1'b1, sa6: nib, sa7_valid: 1'b1, sa7: b, zero_run: z};
      @(posedge aclk);
      evt.sa6_valid <= 0;
      evt.sa7_valid <= 0;
      // Expected flags: entry and exit for each pattern, entry only for misc
      f6 |= ((sa6_class(nib) ^ prev6) & 6'b111101) | (sa6_class(nib) & ~prev6 & 6'b000010);
      prev6 = sa6_class(nib);
      hist = {hist[1:0], b};
      seen = (seen < 3) ? seen + 1 : 3;
      prev_st = st;
      if (seen == 3) st = (3 - hist[0] - hist[1] - hist[2]) >= 2;
      if (st != prev_st) f2[1] = 1;
      repeat (3) @(posedge aclk);
      if (i > 0) check(irq, (|(f6 & en6[5:0])) | (|(f2 & en2[1:0])));
      axi_rd(`ENF_ZSTAT_OFS, d, r);
      check(d[5], st);
      check(d[1], f2[1]);
      check(d[0], f2[0]);
      axi_rd(`ENF_SA6_FLAG_OFS, d, r);
      if (i == 0) check(d & 32'hffff_fffd, 32'(f6 & 6'b111101));
      else check(d, 32'(f6));
      // Both status reads clear every sticky flag
      f6 = '0;
      f2 = '0;
      repeat (2) @(posedge aclk);
      if (i > 0 && !(|(f2 & en2[1:0]))) check(irq, 1'b0);
    end
    // Zero-run detect and clear, each latching once and clearing on read
    axi_rd(`ENF_ZSTAT_OFS, d, r);
    axi_wr(`ENF_ZIRQ_EN_OFS, 32'h0000_0001, 4'hf, r);
    repeat (2) begin
      @(posedge aclk);
      evt.zero_run <= ~evt.zero_run;
      repeat (4) @(posedge aclk);
      check(irq, 1'b1);
      axi_rd(`ENF_ZSTAT_OFS, d, r);
      check(d[0], 1'b1);
      axi_rd(`ENF_ZSTAT_OFS, d, r);
      check(d[0], 1'b0);
      repeat (2) @(posedge aclk);
      check(irq, 1'b0);
    end
    // Mid-run reset, held two edges so no stale history survives into the checks
    axi_wr(`ENF_SA6_IRQ_EN_OFS, 32'h0000_003f, 4'hf, r);
    axi_wr(`ENF_ZIRQ_EN_OFS, 32'h0000_0003, 4'hf, r);
    @(posedge aclk);
    aresetn <= 0;
    evt <= '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    for (i = 0; i < 4; i++) begin
      axi_rd(12'(i * 4), d, r);
      check(d, 32'h0000_0000);
    end
    check(irq, 1'b0);
    test_done();
  end
endmodule
